/* src/swc_pkg.sv */
// Constants, carrier types and decode helpers of the single-wire configuration port.
// Assumes a 100 MHz core clock and an open-drain line with an external pull-up.
// Functional notes
// (RULE1) Bytes move half duplex at 9600 bit/s, eight data bits per frame.
// (RULE2) Low start bit, high stop bit, idle high: ten bit times per byte.
// (RULE3) Falling edge starts frame; first sample 24 minus 2 ticks later, then every 16.
// (RULE4) With enable low the port never sends a message of its own.
// (RULE5) Host commands are answered whatever the enable level.
// (RULE6) A reply begins within 3.125 ms of the command's last bit.
// (RULE7) No transmission starts while a packet is still on the line.
// (RULE8) Host watches for contention, backs off three packet times.
// (RULE9) Low-power mode change waits until the message in flight is done.
// (RULE10) Command byte: bit 7 set, bits 6 and 5 zero, code in bits 4 to 0.
// (RULE11) Host message is a command byte, plus a data byte only when needed.
// (RULE12) Missing data byte: not-acknowledge after 5 ms of silence.
// (RULE13) Reply echoes command with bit 7 clear, bit 6 the acknowledge, then data.
// (RULE14) Unsupported or malformed commands receive a not-acknowledge.
// (RULE15) Unsolicited messages may be sent; host need not reply.
// (RULE16) Unsolicited status report only when a status bit becomes active.
// (RULE17) Reported faults clear on status request or enable toggle, unless still present.
// (RULE18) Restart sets the brown-out flag and one unsolicited report follows.
// (RULE19) Brown-out flag clears when the acknowledged status-1 reply is sent; the code clears it when the status-1 command is decoded, before the reply.
// (RULE20) Configuration writes are accepted at any time.
// (RULE21) Status requests return the current status register contents.
// (RULE22) Configuration-1 write sets the current-limit DAC code; read returns it.
// (RULE23) Codes 81H to 87H: write/read cfg0, write/read cfg1, status0, status1, write cfg2.
// (RULE24) A tick at sixteen times the baud rate times both receive and transmit.

package swc_pkg;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int unsigned CLK_HZ           = 100_000_000;
   localparam int unsigned CLK_PERIOD_NS    = 10;
   localparam int unsigned BAUD             = 9600;
   localparam int unsigned OVERSAMPLE       = 16;
   localparam int unsigned TICK_DIV         = CLK_HZ / (BAUD * OVERSAMPLE);
   localparam int unsigned START_TICKS      = 24;
   localparam int unsigned SYNC_TICKS       = 2;
   localparam int unsigned FIRST_SAMPLE     = START_TICKS - SYNC_TICKS;
   localparam int unsigned BIT_TICKS        = 16;
   localparam int unsigned DATA_BITS        = 8;
   localparam int unsigned FRAME_BITS       = 10;
   localparam int unsigned RESP_MAX_NS      = 3_125_000;
   localparam int unsigned RESP_MAX_CYC     = RESP_MAX_NS / CLK_PERIOD_NS;
   localparam int unsigned DATA_TMO_NS      = 5_000_000;
   localparam int unsigned DATA_TMO_CYC     = (DATA_TMO_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // ----------------------------------------------------------------
   // Byte layout and command codes
   // ----------------------------------------------------------------
   localparam int unsigned CMD_MARK_BIT     = 7;
   localparam int unsigned ACK_BIT          = 6;
   localparam logic [4:0]  CMD_SET_CFG0     = 5'h01;
   localparam logic [4:0]  CMD_GET_CFG0     = 5'h02;
   localparam logic [4:0]  CMD_SET_CFG1     = 5'h03;
   localparam logic [4:0]  CMD_GET_CFG1     = 5'h04;
   localparam logic [4:0]  CMD_STATUS0      = 5'h05;
   localparam logic [4:0]  CMD_STATUS1      = 5'h06;
   localparam logic [4:0]  CMD_SET_CFG2     = 5'h07;

   // ----------------------------------------------------------------
   // Reset values and field positions
   // ----------------------------------------------------------------
   localparam logic [7:0]  CFG0_RST         = 8'h00;
   localparam logic [7:0]  CFG1_RST         = 8'h40;
   localparam logic [7:0]  CFG2_RST         = 8'h00;
   localparam int unsigned BROWN_OUT_BIT    = 0;

   typedef struct packed {
      logic [7:0] cfg0;
      logic [7:0] cfg1;
      logic [7:0] cfg2;
   } cfg_s;

   typedef struct packed {
      logic [7:0] reg0;
      logic [7:0] reg1;
   } status_s;

   function automatic logic needs_data(input logic [4:0] code);
      needs_data = (code == CMD_SET_CFG0) || (code == CMD_SET_CFG1) || (code == CMD_SET_CFG2);
   endfunction : needs_data

   function automatic logic known_cmd(input logic [4:0] code);
      known_cmd = (code >= CMD_SET_CFG0) && (code <= CMD_SET_CFG2);
   endfunction : known_cmd

endpackage : swc_pkg

/* src/swc_baud_tick.sv */
// Oversampling tick generator: one-cycle pulse every DIV clocks.
// Assumes the core clock named in the package.
`timescale 1ns/1ps

module swc_baud_tick #(
   parameter int unsigned DIV = swc_pkg::TICK_DIV
) (
   // Clock and reset
   input  wire logic clock_i,
   input  wire logic arst_n_i,
   // Tick
   output logic      tick_o
);
   import swc_pkg::*;

   localparam int unsigned CW = $clog2(DIV);

   typedef struct packed {
      logic [CW-1:0] cnt;
      logic          tick;
   } tick_state_s;

   tick_state_s s_ff;
   tick_state_s nxt_s;

   always_comb begin
      nxt_s = s_ff;
      nxt_s.tick = 1'b0;
      if (s_ff.cnt == CW'(DIV - 1)) begin  // RULE24
         nxt_s.cnt  = '0;
         nxt_s.tick = 1'b1;
      end else begin
         nxt_s.cnt = s_ff.cnt + 1'b1;
      end
   end

   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         s_ff <= '0;
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign tick_o = s_ff.tick;

endmodule : swc_baud_tick

/* src/swc_byte_tx.sv */
// Byte serializer for the open-drain line: start bit, eight data bits LSB first, stop bit.
// Assumes tick_i pulses at sixteen times the baud rate.
`timescale 1ns/1ps

module swc_byte_tx (
   // Clock and reset
   input  wire logic       clock_i,
   input  wire logic       arst_n_i,
   // Request
   input  wire logic       tick_i,
   input  wire logic       start_i,
   input  wire logic [7:0] byte_i,
   // Line and status
   output logic            line_o,
   output logic            line_oe_o,
   output logic            busy_o,
   output logic            done_o
);
   import swc_pkg::*;

   typedef struct packed {
      logic       busy;
      logic [9:0] shift;
      logic [3:0] bit_cnt;
      logic [3:0] tick_cnt;
      logic       line;
      logic       oe;
      logic       done;
   } tx_state_s;

   tx_state_s s_ff;
   tx_state_s nxt_s;

   always_comb begin
      nxt_s = s_ff;
      nxt_s.done = 1'b0;
      if (!s_ff.busy) begin
         if (start_i) begin
            nxt_s.busy     = 1'b1;
            nxt_s.shift    = {1'b1, byte_i, 1'b0};  // RULE2
            nxt_s.bit_cnt  = '0;
            nxt_s.tick_cnt = 4'(BIT_TICKS - 1);
            nxt_s.line     = 1'b0;
            nxt_s.oe       = 1'b1;
         end
      end else if (tick_i) begin
         if (s_ff.tick_cnt != '0) begin
            nxt_s.tick_cnt = s_ff.tick_cnt - 1'b1;
         end else if (s_ff.bit_cnt == 4'(FRAME_BITS - 1)) begin  // RULE1
            nxt_s.busy = 1'b0;
            nxt_s.done = 1'b1;
            nxt_s.line = 1'b1;
            nxt_s.oe   = 1'b0;
         end else begin
            nxt_s.bit_cnt  = s_ff.bit_cnt + 1'b1;
            nxt_s.shift    = {1'b1, s_ff.shift[9:1]};
            nxt_s.line     = s_ff.shift[1];
            nxt_s.oe       = ~s_ff.shift[1];
            nxt_s.tick_cnt = 4'(BIT_TICKS - 1);  // RULE24
         end
      end
   end

   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         s_ff      <= '0;
         s_ff.line <= 1'b1;
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign line_o    = s_ff.line;
   assign line_oe_o = s_ff.oe;
   assign busy_o    = s_ff.busy;
   assign done_o    = s_ff.done;

endmodule : swc_byte_tx

/* src/single_wire_config_port.sv */
// Single-wire configuration port: receiver, command handling, replies and reports.
// Assumes the line input is synchronous to clock_i and pulled up outside.
`timescale 1ns/1ps

module single_wire_config_port #(
   parameter int unsigned BAUD_DIV = swc_pkg::TICK_DIV,
   parameter int unsigned DATA_TMO = swc_pkg::DATA_TMO_CYC
) (
   // Clock and reset
   input  wire logic            clock_i,
   input  wire logic            arst_n_i,
   // Open-drain line
   input  wire logic            single_wire_config_line_i,
   output logic                 single_wire_config_line_o,
   output logic                 single_wire_config_line_oe_o,
   // Device control
   input  wire logic            enable_i,
   input  wire logic            restart_i,
   input  wire logic            lowpower_req_i,
   output logic                 lowpower_go_o,
   // Status conditions and registers
   input  wire swc_pkg::status_s status_cond_i,
   output swc_pkg::status_s      status_o,
   // Configuration
   output swc_pkg::cfg_s         cfg_o
);
   import swc_pkg::*;

   localparam int unsigned TW = $clog2(DATA_TMO + 1);

   typedef enum logic [0:0] {
      R_IDLE,
      R_BITS
   } rx_state_e;

   typedef enum logic [1:0] {
      P_IDLE,
      P_WAIT_DATA,
      P_LAUNCH,
      P_DRAIN
   } proto_state_e;

   typedef struct packed {
      rx_state_e    rx_st;
      logic         line_prev;
      logic [4:0]   rx_tick_cnt;
      logic [3:0]   rx_bit_cnt;
      logic [7:0]   rx_shift;
      logic         rx_valid;
      logic [7:0]   rx_byte;
      proto_state_e p_st;
      logic [4:0]   cmd;
      logic [TW-1:0] tmo_cnt;
      logic [7:0]   cur;
      logic [7:0]   dat;
      logic         two;
      logic         tx_start;
      cfg_s         cfg;
      status_s      stat;
      logic         bo_flag;
      logic         pend0;
      logic         pend1;
      logic         en_prev;
      logic         lowpower_go;
   } port_state_s;

   port_state_s s_ff;
   port_state_s nxt_s;

   logic tick;
   logic tx_busy;
   logic tx_done;
   logic tx_line;
   logic tx_oe;

   // ----------------------------------------------------------------
   // Bit timing and transmitter
   // ----------------------------------------------------------------
   swc_baud_tick #(
      .DIV      (BAUD_DIV)
   ) u_tick (
      .clock_i  (clock_i),
      .arst_n_i (arst_n_i),
      .tick_o   (tick)
   );

   swc_byte_tx u_tx (
      .clock_i   (clock_i),
      .arst_n_i  (arst_n_i),
      .tick_i    (tick),
      .start_i   (s_ff.tx_start),
      .byte_i    (s_ff.cur),
      .line_o    (tx_line),
      .line_oe_o (tx_oe),
      .busy_o    (tx_busy),
      .done_o    (tx_done)
   );

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      logic       rx_busy;
      logic       en_rise;
      logic       clr0;
      logic       clr1;
      logic       bo_clr;
      logic [7:0] rb;
      logic [7:0] rise0;
      logic [7:0] rise1;
      rx_busy = 1'b0;
      en_rise = 1'b0;
      clr0    = 1'b0;
      clr1    = 1'b0;
      bo_clr  = 1'b0;
      rb      = '0;
      rise0   = '0;
      rise1   = '0;

      nxt_s = s_ff;
      nxt_s.rx_valid  = 1'b0;
      nxt_s.tx_start  = 1'b0;
      nxt_s.line_prev = single_wire_config_line_i;
      nxt_s.en_prev   = enable_i;
      en_rise = enable_i & ~s_ff.en_prev;

      // Receiver, muted while our own frame is on the line
      case (s_ff.rx_st)
         R_IDLE: begin
            if (!tx_busy && !s_ff.tx_start && s_ff.line_prev
                && !single_wire_config_line_i) begin  // RULE3
               nxt_s.rx_st       = R_BITS;
               nxt_s.rx_tick_cnt = 5'(FIRST_SAMPLE - 1);
               nxt_s.rx_bit_cnt  = '0;
            end
         end
         R_BITS: begin
            if (tick) begin
               if (s_ff.rx_tick_cnt != '0) begin
                  nxt_s.rx_tick_cnt = s_ff.rx_tick_cnt - 1'b1;
               end else if (s_ff.rx_bit_cnt == 4'(DATA_BITS)) begin
                  nxt_s.rx_st    = R_IDLE;
                  nxt_s.rx_valid = single_wire_config_line_i;  // RULE2
                  nxt_s.rx_byte  = s_ff.rx_shift;
               end else begin
                  nxt_s.rx_shift    = {single_wire_config_line_i, s_ff.rx_shift[7:1]};
                  nxt_s.rx_bit_cnt  = s_ff.rx_bit_cnt + 1'b1;
                  nxt_s.rx_tick_cnt = 5'(BIT_TICKS - 1);  // RULE3
               end
            end
         end
         default: begin
            nxt_s.rx_st = R_IDLE;
         end
      endcase
      rx_busy = (s_ff.rx_st != R_IDLE);

      // Command handling and replies
      rb = s_ff.rx_byte;
      case (s_ff.p_st)
         P_IDLE: begin
            if (s_ff.rx_valid && rb[CMD_MARK_BIT]) begin
               nxt_s.two  = 1'b0;
               nxt_s.p_st = P_LAUNCH;  // RULE5
               if ((rb[6:5] != 2'b00) || !known_cmd(rb[4:0])) begin  // RULE10
                  nxt_s.cur = {2'b00, rb[5:0]};  // RULE14
               end else if (needs_data(rb[4:0])) begin  // RULE11
                  nxt_s.cmd     = rb[4:0];
                  nxt_s.tmo_cnt = '0;
                  nxt_s.p_st    = P_WAIT_DATA;
               end else begin
                  nxt_s.cur = {2'b01, rb[5:0]};  // RULE13
                  nxt_s.two = 1'b1;
                  case (rb[4:0])
                     CMD_GET_CFG0: nxt_s.dat = s_ff.cfg.cfg0;
                     CMD_GET_CFG1: nxt_s.dat = s_ff.cfg.cfg1;  // RULE22
                     CMD_STATUS0: begin
                        nxt_s.dat = s_ff.stat.reg0;  // RULE21
                        clr0      = 1'b1;  // RULE17
                     end
                     CMD_STATUS1: begin
                        nxt_s.dat = s_ff.stat.reg1;  // RULE21
                        clr1      = 1'b1;
                        bo_clr    = 1'b1;  // RULE19
                     end
                     default: nxt_s.two = 1'b0;
                  endcase
               end
            end else if (!s_ff.rx_valid && !rx_busy && enable_i
                         && (s_ff.pend0 || s_ff.pend1)) begin  // RULE4
               nxt_s.two  = 1'b1;
               nxt_s.p_st = P_LAUNCH;  // RULE15
               if (s_ff.pend1) begin
                  nxt_s.cur   = {3'b010, CMD_STATUS1};
                  nxt_s.dat   = s_ff.stat.reg1;
                  nxt_s.pend1 = 1'b0;
               end else begin
                  nxt_s.cur   = {3'b010, CMD_STATUS0};
                  nxt_s.dat   = s_ff.stat.reg0;
                  nxt_s.pend0 = 1'b0;
               end
            end
         end
         P_WAIT_DATA: begin
            if (s_ff.rx_valid) begin
               case (s_ff.cmd)  // RULE20
                  CMD_SET_CFG0: nxt_s.cfg.cfg0 = rb;
                  CMD_SET_CFG1: nxt_s.cfg.cfg1 = rb;  // RULE22
                  default:      nxt_s.cfg.cfg2 = rb;
               endcase
               nxt_s.cur  = {3'b010, s_ff.cmd};  // RULE13
               nxt_s.p_st = P_LAUNCH;
            end else if (rx_busy) begin
               nxt_s.tmo_cnt = '0;
            end else if (s_ff.tmo_cnt == TW'(DATA_TMO - 1)) begin  // RULE12
               nxt_s.cur  = {3'b000, s_ff.cmd};
               nxt_s.p_st = P_LAUNCH;
            end else begin
               nxt_s.tmo_cnt = s_ff.tmo_cnt + 1'b1;
            end
         end
         P_LAUNCH: begin
            if (!tx_busy && !rx_busy && single_wire_config_line_i) begin  // RULE7
               nxt_s.tx_start = 1'b1;  // RULE6
               nxt_s.p_st     = P_DRAIN;
            end
         end
         P_DRAIN: begin
            if (tx_done) begin
               if (s_ff.two) begin
                  nxt_s.cur  = s_ff.dat;
                  nxt_s.two  = 1'b0;
                  nxt_s.p_st = P_LAUNCH;
               end else begin
                  nxt_s.p_st = P_IDLE;
               end
            end
         end
         default: begin
            nxt_s.p_st = P_IDLE;
         end
      endcase

      // Status latching: a live condition wins over a clear, except reg1 bit 0, which always follows bo_flag
      nxt_s.bo_flag   = restart_i | (s_ff.bo_flag & ~bo_clr);  // RULE18
      nxt_s.stat.reg0 = status_cond_i.reg0
                        | (s_ff.stat.reg0 & ~{8{clr0 | en_rise}});  // RULE17
      nxt_s.stat.reg1 = status_cond_i.reg1
                        | (s_ff.stat.reg1 & ~{8{clr1 | en_rise}});
      nxt_s.stat.reg1[BROWN_OUT_BIT] = nxt_s.bo_flag;
      rise0 = nxt_s.stat.reg0 & ~s_ff.stat.reg0;
      rise1 = nxt_s.stat.reg1 & ~s_ff.stat.reg1;
      if (rise0 != '0) begin
         nxt_s.pend0 = 1'b1;  // RULE16
      end
      if (rise1 != '0) begin
         nxt_s.pend1 = 1'b1;  // RULE18
      end

      // Mode change only with nothing in flight
      nxt_s.lowpower_go = lowpower_req_i && !rx_busy && !tx_busy && !s_ff.rx_valid
                          && !s_ff.tx_start && (s_ff.p_st == P_IDLE);  // RULE9
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         s_ff           <= '0;
         s_ff.rx_st     <= R_IDLE;
         s_ff.p_st      <= P_IDLE;
         s_ff.line_prev <= 1'b1;
         s_ff.cfg.cfg0  <= CFG0_RST;
         s_ff.cfg.cfg1  <= CFG1_RST;
         s_ff.cfg.cfg2  <= CFG2_RST;
         s_ff.bo_flag   <= 1'b1;
      end else begin
         s_ff <= nxt_s;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign single_wire_config_line_o    = tx_line;
   assign single_wire_config_line_oe_o = tx_oe;
   assign lowpower_go_o                = s_ff.lowpower_go;
   assign status_o                     = s_ff.stat;
   assign cfg_o                        = s_ff.cfg;

endmodule : single_wire_config_port

/* test/single_wire_config_port_monitor.sv */
// Port-level checker of the single-wire configuration port.
// Assumes bind to the top module; single clock domain.
`timescale 1ns/1ps
module single_wire_config_port_monitor
   import swc_pkg::*;
#(
   parameter int unsigned DIV      = TICK_DIV,
   parameter int unsigned DATA_TMO = DATA_TMO_CYC
) (
   input wire logic    clock_i,
   input wire logic    arst_n_i,
   input wire logic    single_wire_config_line_i,
   input wire logic    single_wire_config_line_o,
   input wire logic    single_wire_config_line_oe_o,
   input wire logic    enable_i,
   input wire logic    restart_i,
   input wire logic    lowpower_req_i,
   input wire logic    lowpower_go_o,
   input wire status_s status_cond_i,
   input wire status_s status_o,
   input wire cfg_s    cfg_o
);
   localparam int unsigned BIT_MIN  = 15 * DIV;
   localparam int unsigned BIT_MAX  = 9 * BIT_TICKS * DIV;
   localparam int unsigned RESP_LIM = RESP_MAX_CYC + 2 * FRAME_BITS * BIT_TICKS * DIV;
   logic        li, oe;
   int unsigned run_ff, quiet_ff;
   assign li = single_wire_config_line_i;
   assign oe = single_wire_config_line_oe_o;
   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         run_ff   <= 0;
         quiet_ff <= RESP_LIM;
      end else begin
         run_ff <= oe ? run_ff + 1 : 0;
         if (!li && !oe)
            quiet_ff <= 0;
         else if (quiet_ff < RESP_LIM)
            quiet_ff <= quiet_ff + 1;
      end
   end
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!arst_n_i);
   sequence s_cfg_upd; !$stable(cfg_o); endsequence
   sequence s_reply; ##[1:8] $rose(oe); endsequence
   property p_drive_low; oe |-> !single_wire_config_line_o; endproperty
   property p_bit_len; $fell(oe) |-> run_ff inside {[BIT_MIN:BIT_MAX]}; endproperty
   property p_turn; $rose(oe) |-> $past(li); endproperty
   property p_reply_time; $rose(oe) && !enable_i |-> quiet_ff < RESP_LIM; endproperty
   property p_lp_req; !lowpower_req_i |=> !lowpower_go_o; endproperty
   property p_lp_tx; oe |-> !lowpower_go_o; endproperty
   property p_lp_rx; $fell(li) && !oe |-> ##3 !lowpower_go_o; endproperty
   property p_cfg_reply; s_cfg_upd |-> s_reply; endproperty
   property p_stat_clr;
      (($past(status_o) & ~status_o & $past(status_cond_i)) & 16'hFFFE) == 16'h0000;
   endproperty
   property p_stat_set;
      (($past(status_cond_i) & $past(status_cond_i, 2) & ~status_o) & 16'hFFFE) == 16'h0000;
   endproperty
   a_drive_low: assert property (p_drive_low) else $error("line enable while high");
   a_bit_len: assert property (p_bit_len) else $error("low run length off");
   a_turn: assert property (p_turn) else $error("sending over a busy line");
   a_reply_time: assert property (p_reply_time) else $error("late or own message");
   a_lp_req: assert property (p_lp_req) else $error("low power without request");
   a_lp_tx: assert property (p_lp_tx) else $error("low power while sending");
   a_lp_rx: assert property (p_lp_rx) else $error("low power while receiving");
   a_cfg_reply: assert property (p_cfg_reply) else $error("write without reply");
   a_stat_clr: assert property (p_stat_clr) else $error("live fault cleared");
   a_stat_set: assert property (p_stat_set) else $error("fault not latched");
endmodule : single_wire_config_port_monitor

bind single_wire_config_port single_wire_config_port_monitor
   #(.DIV(BAUD_DIV), .DATA_TMO(DATA_TMO)) u_mon (
   .clock_i(clock_i), .arst_n_i(arst_n_i),
   .single_wire_config_line_i(single_wire_config_line_i),
   .single_wire_config_line_o(single_wire_config_line_o),
   .single_wire_config_line_oe_o(single_wire_config_line_oe_o),
   .enable_i(enable_i), .restart_i(restart_i), .lowpower_req_i(lowpower_req_i),
   .lowpower_go_o(lowpower_go_o), .status_cond_i(status_cond_i),
   .status_o(status_o), .cfg_o(cfg_o));

/* test/swc_host_model.sv */
// Host model: open-drain UART at the device bit time.
// Assumes the bench forms the wire from both pull-down enables.
`timescale 1ns/1ps
module swc_host_model #(
   parameter int BIT  = 10416,
   parameter int WAIT = 312600
) (
   input  wire logic clock_i,
   input  wire logic line_i,
   output logic      line_oe_o
);
   initial line_oe_o = 1'b0;
   // Start low, data LSB first, stop high; backs off on contention
   task automatic send(input logic [7:0] b);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         line_oe_o <= !f[i];
         repeat (BIT / 2) @(posedge clock_i);
         if (f[i] && !line_i) begin
            line_oe_o <= 1'b0;
            repeat (30 * BIT) @(posedge clock_i);
            return;
         end
         repeat (BIT - BIT / 2) @(posedge clock_i);
      end
   endtask : send
   // Waits a bounded time for a start bit, samples mid-bit
   task automatic recv(output logic [7:0] b, output logic got);
      int n;
      got = 1'b0;
      b = 8'h00;
      n = 0;
      while (line_i && n < WAIT) begin
         @(posedge clock_i);
         n++;
      end
      if (line_i) return;
      repeat (BIT + BIT / 2) @(posedge clock_i);
      for (int i = 0; i < 8; i++) begin
         b[i] = line_i;
         repeat (BIT) @(posedge clock_i);
      end
      got = line_i;
   endtask : recv
endmodule : swc_host_model

/* test/single_wire_config_port_test.sv */
// Self-checking bench of the single-wire configuration port.
// Assumes the host model and a pull-up on the shared wire.
`timescale 1ns/1ps
module single_wire_config_port_test;
   import swc_pkg::*;
   localparam int BIT = BIT_TICKS * 8;
   logic        clock_i = 1'b0;
   logic        arst_n_i, enable_i, restart_i, lowpower_req_i;
   logic        line, dut_line, dut_oe, host_oe, lp_go, g;
   status_s     cond_i, status_o;
   cfg_s        cfg_o;
   logic [15:0] seed;
   logic [7:0]  b, f;
   logic [7:0]  wc [3] = '{8'h81, 8'h83, 8'h87};
   logic [7:0]  bad [4] = '{8'h88, 8'hA1, 8'hC5, 8'h80};
   int          err_count = 0;
   int          n_checks = 0;
   assign line = !(dut_oe || host_oe);
   always #5 clock_i = !clock_i;
   single_wire_config_port #(.BAUD_DIV(8), .DATA_TMO(400)) u_single_wire_config_port (
      .clock_i(clock_i), .arst_n_i(arst_n_i), .single_wire_config_line_i(line),
      .single_wire_config_line_o(dut_line), .single_wire_config_line_oe_o(dut_oe),
      .enable_i(enable_i), .restart_i(restart_i), .lowpower_req_i(lowpower_req_i),
      .lowpower_go_o(lp_go), .status_cond_i(cond_i), .status_o(status_o), .cfg_o(cfg_o));
   swc_host_model #(.BIT(BIT), .WAIT(2000)) u_swc_host_model (
      .clock_i(clock_i), .line_i(line), .line_oe_o(host_oe));
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr
   function automatic logic [7:0] exp_hdr(input logic [7:0] c, input logic hd);
      logic ok;
      ok = c[7] && c[6:5] == 2'b00 && c[4:0] inside {[5'h01:5'h07]}
           && (hd || !(c[4:0] inside {5'h01, 5'h03, 5'h07}));
      return {1'b0, ok, c[5:0]};
   endfunction : exp_hdr
   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic rx(input string nm, input logic [7:0] e);
      u_swc_host_model.recv(b, g);
      chk({nm, " stop"}, {7'h00, g}, 8'h01);
      chk(nm, b, e);
   endtask : rx
   task automatic quiet();
      u_swc_host_model.recv(b, g);
      chk("quiet", {7'h00, g}, 8'h00);
   endtask : quiet
   task automatic xact(input logic [7:0] c, input logic hd, input logic [7:0] d,
                       input logic [7:0] rv);
      logic [7:0] h;
      h = exp_hdr(c, hd);
      repeat (BIT) @(posedge clock_i);
      fork
         begin
            u_swc_host_model.send(c);
            if (hd) u_swc_host_model.send(d);
         end
         begin
            repeat (BIT * 5) @(posedge clock_i);
            chk("lp_go busy", {7'h00, lp_go}, 8'h00);
         end
         begin
            repeat (BIT * (hd ? 19 : 9) + 2) @(posedge clock_i);
            rx("hdr", h);
            if (h[6] && c[4:0] inside {5'h02, 5'h04, 5'h05, 5'h06}) rx("data", rv);
         end
      join
   endtask : xact
   task automatic results();
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : results
   initial begin
      #900_000;
      err_count++;
      results();
   end
   initial begin
      arst_n_i = 1'b0;
      enable_i = 1'b0;
      restart_i = 1'b0;
      lowpower_req_i = 1'b0;
      cond_i = '0;
      seed = 16'h9A83;
      repeat (20) @(posedge clock_i);
      arst_n_i <= 1'b1;
      lowpower_req_i <= 1'b1;
      repeat (3) @(posedge clock_i);
      chk("cfg reset", 8'(cfg_o >> 16), CFG0_RST);
      chk("cfg reset", cfg_o.cfg1, CFG1_RST);
      chk("cfg reset", cfg_o.cfg2, CFG2_RST);
      chk("brown out", {7'h00, status_o.reg1[BROWN_OUT_BIT]}, 8'h01);
      quiet();
      enable_i <= 1'b1;
      rx("unsol", 8'h46);
      rx("unsol data", 8'h01);
      quiet();
      chk("lp_go idle", {7'h00, lp_go}, 8'h01);
      $display("test power-up report done");
      enable_i <= 1'b0;
      xact(8'h86, 1'b0, 8'h00, 8'h01);
      chk("brown out", {7'h00, status_o.reg1[BROWN_OUT_BIT]}, 8'h00);
      for (int k = 0; k < 3; k++) begin
         seed = lfsr(seed);
         xact(wc[k], 1'b1, seed[7:0], 8'h00);
         chk("cfg", 8'(cfg_o >> (16 - 8 * k)), seed[7:0]);
         if (k < 2) xact(wc[k] + 8'h01, 1'b0, 8'h00, seed[7:0]);
      end
      foreach (bad[i]) xact(bad[i], 1'b0, 8'h00, 8'h00);
      xact(8'h83, 1'b0, 8'h00, 8'h00);
      $display("test commands done");
      enable_i <= 1'b1;
      seed = lfsr(seed);
      f = 8'h01 << seed[2:0];
      cond_i.reg0 <= f;
      rx("unsol", 8'h45);
      rx("unsol data", f);
      cond_i.reg0 <= 8'h00;
      quiet();
      cond_i.reg0 <= f;
      @(posedge clock_i);
      enable_i <= 1'b0;
      repeat (10) @(posedge clock_i);
      enable_i <= 1'b1;
      repeat (5) @(posedge clock_i);
      chk("live fault", status_o.reg0, f);
      cond_i.reg0 <= 8'h00;
      xact(8'h85, 1'b0, 8'h00, f);
      chk("fault clear", status_o.reg0, 8'h00);
      restart_i <= 1'b1;
      @(posedge clock_i);
      restart_i <= 1'b0;
      rx("unsol", 8'h46);
      rx("unsol data", 8'h01);
      $display("test faults done");
      results();
   end
endmodule : single_wire_config_port_test
